// >>> core/dfwh_word_handler.sv
// Command and condition word handler for the alternative bus profile
// Operation
// - Words are interpreted only while the profile selection is option 0; in any profile the setpoint still passes and stop b/c sets inhibit.
// - Any of command bits 0,1,2 low requests a ramped stop.
// - With ramp-stop relay option, energise relay when output frequency is zero.
// - Command bits 0,1,2 all high permit start if other conditions hold.
// - Command bit 8 selects first bus jog frequency.
// - Command bit 9 selects second bus jog frequency.
// - Command bit 11 lowers the reference by the adjustment amount.
// - Command bit 12 raises the reference by the adjustment amount.
// - Bits 11 and 12 both high: lowering wins.
// - Condition bit 0 high only when bits 0,1,2 high and drive ready.
// - Condition bit 2 high only when command bits 0-3 high, no trip.
// - Condition bit 4 is the inverse of command bit 1.
// - Condition bit 5 is the inverse of command bit 2.
// - Start inhibit set at trip reset, stop b/c, power-up; cleared by pattern.
// - Condition word reports trip, warnings, speed, serial, limits, running flags.
// - Reference is signed 16-bit, 16384 is 100 percent, limit 32767.
// - Negative reference in two's complement reverses rotation.
// - Output frequency returned as signed 16-bit, 16384 is 100 percent.
// - Station address ranges by protocol; default address 1.
// - Station address changes from the serial link are refused.
// - Bit rate code 0-5 selects 300 to 9600; default 5.
module dfwh_word_handler
  import dfwh_pkg::*;
(
  input wire logic mclk_i,              // System clock, 250 MHz
  input wire logic srst_i,              // Synchronous reset, active high
  input wire logic [1:0] profile_i,     // Message profile selection
  input wire logic cmd_we_i,            // Command word write strobe
  input wire logic [15:0] cmd_word_i,   // Command word from the master
  input wire logic ref_we_i,            // Speed setpoint write strobe
  input wire logic [15:0] ref_word_i,   // Speed setpoint from the master
  input wire logic [15:0] adj_amt_i,    // Slow-down/catch-up amount
  input wire logic [15:0] jog1_freq_i,  // First bus jog frequency
  input wire logic [15:0] jog2_freq_i,  // Second bus jog frequency
  input wire logic [15:0] out_freq_i,   // Present output frequency from core
  input wire logic start_cond_i,        // Other start conditions met
  input wire logic relay_sel_i,         // Relay set to ramp-stop indication
  input wire logic drive_ready_i,       // Drive ready for operation
  input wire logic trip_i,              // Trip present
  input wire logic warn_i,              // Warning present
  input wire logic at_ref_i,            // Speed equals reference
  input wire logic ser_allowed_i,       // Serial control allowed
  input wire logic in_limits_i,         // Frequency within limits
  input wire logic running_i,           // Motor running
  input wire logic volt_warn_i,         // DC voltage warning
  input wire logic cur_limit_i,         // Current limit active
  input wire logic therm_warn_i,        // Thermal warning
  input wire logic [1:0] protocol_i,    // Serial protocol selection
  input wire logic loc_addr_we_i,       // Local unit address write
  input wire logic [7:0] loc_addr_i,    // Local unit address value
  input wire logic loc_baud_we_i,       // Local unit bit rate write
  input wire logic [2:0] loc_baud_i,    // Local unit bit rate code
  input wire logic ser_cfg_we_i,        // Serial attempt to change address/rate
  output logic [15:0] status_word_o,    // Condition word to the master
  output logic [15:0] out_freq_word_o,  // Output frequency word to the master
  output logic [15:0] speed_cmd_o,      // Shaped frequency command to core
  output logic jog_active_o,            // Jog frequency in use
  output logic ramp_stop_o,             // Ramped stop request
  output logic start_permit_o,          // Motor start permitted
  output logic relay_o,                 // Output relay energised
  output logic [7:0] station_addr_o,    // Station address
  output logic [2:0] baud_code_o,       // Serial bit rate code
  output logic cfg_refused_o            // Configuration write refused, pulse
);

  dfwh_top_st_t st_reg;
  dfwh_top_st_t st_next;
  logic active;
  logic halt_ok;
  logic inhibit_set;
  logic inhibit_clr;

  dfwh_ref_if rif ();

  // ----------------------------------------
  // Address range by protocol
  // ----------------------------------------
  function automatic logic addr_ok(input logic [1:0] proto, input logic [7:0] a);
    case (proto)
      PROTO_NATIVE: return a <= ADDR_NATIVE_MAX;
      PROTO_BAS: return a >= ADDR_ONE && a <= ADDR_BAS_MAX;
      PROTO_RTU: return a >= ADDR_ONE && a <= ADDR_RTU_MAX;
      default: return 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    active = profile_i == PROFILE_ALT;
    halt_ok = &st_reg.cmd[CW_HALT_C:CW_HALT_A];
    if (cmd_we_i)
    begin
      st_next.cmd = cmd_word_i;
    end
    if (ref_we_i)
    begin
      st_next.setpoint = ref_word_i;
    end
    st_next.ramp_stop = active & ~halt_ok;
    st_next.start_ok = active & halt_ok & start_cond_i;
    st_next.relay = active & relay_sel_i & (out_freq_i == WORD_RST);
    st_next.freq = out_freq_i;
    // Inhibit set events win over the clearing pattern
    st_next.trip_d = trip_i;
    inhibit_set = (st_reg.trip_d & ~trip_i)
      | (cmd_we_i & st_reg.cmd[CW_HALT_B] & ~cmd_word_i[CW_HALT_B])
      | (cmd_we_i & st_reg.cmd[CW_HALT_C] & ~cmd_word_i[CW_HALT_C]);
    inhibit_clr = active & ~st_reg.cmd[CW_HALT_A] & st_reg.cmd[CW_HALT_B]
      & st_reg.cmd[CW_HALT_C] & st_reg.cmd[CW_DATA_OK];
    if (inhibit_set)
    begin
      st_next.inhibit = 1'b1;
    end
    else if (inhibit_clr)
    begin
      st_next.inhibit = 1'b0;
    end
    st_next.status = WORD_RST;
    if (active)
    begin
      st_next.status[SW_CTRL_RDY] = halt_ok & drive_ready_i;
      st_next.status[SW_DRV_RDY] = drive_ready_i;
      st_next.status[SW_COAST_OK] = &st_reg.cmd[CW_COAST_N:CW_HALT_A] & ~trip_i;
      st_next.status[SW_TRIP] = trip_i;
      st_next.status[SW_HALT_B] = ~st_reg.cmd[CW_HALT_B];
      st_next.status[SW_HALT_C] = ~st_reg.cmd[CW_HALT_C];
      st_next.status[SW_INHIBIT] = st_reg.inhibit;
      st_next.status[SW_WARN] = warn_i;
      st_next.status[SW_AT_REF] = at_ref_i;
      st_next.status[SW_SER_OK] = ser_allowed_i;
      st_next.status[SW_IN_LIM] = in_limits_i;
      st_next.status[SW_RUN] = running_i;
      st_next.status[SW_SPARE] = 1'b0;
      st_next.status[SW_VOLT] = volt_warn_i;
      st_next.status[SW_CUR_LIM] = cur_limit_i;
      st_next.status[SW_THERM] = therm_warn_i;
    end
    // Local unit writes only; any serial attempt is refused
    st_next.refused = ser_cfg_we_i;
    if (loc_addr_we_i)
    begin
      if (addr_ok(protocol_i, loc_addr_i))
      begin
        st_next.addr = loc_addr_i;
      end
      else
      begin
        st_next.refused = 1'b1;
      end
    end
    if (loc_baud_we_i)
    begin
      if (loc_baud_i <= BAUD_MAX)
      begin
        st_next.baud = loc_baud_i;
      end
      else
      begin
        st_next.refused = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_reg <= '{cmd: CMD_RST, setpoint: WORD_RST, status: WORD_RST, freq: WORD_RST,
                  addr: ADDR_RST, baud: BAUD_RST, inhibit: INHIBIT_RST, trip_d: 1'b0,
                  ramp_stop: 1'b0, start_ok: 1'b0, relay: 1'b0, refused: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Reference shaper
  // ----------------------------------------
  assign rif.setpoint = st_reg.setpoint;
  assign rif.adj_amt = adj_amt_i;
  assign rif.jog1_freq = jog1_freq_i;
  assign rif.jog2_freq = jog2_freq_i;
  assign rif.slow = active & st_reg.cmd[CW_SLOW];
  assign rif.catch_up = active & st_reg.cmd[CW_CATCH];
  assign rif.jog1 = active & st_reg.cmd[CW_JOG1];
  assign rif.jog2 = active & st_reg.cmd[CW_JOG2];

  dfwh_ref_shaper u_shaper
  (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .rif(rif.shaper)
  );

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign status_word_o = st_reg.status;
  assign out_freq_word_o = st_reg.freq;
  assign speed_cmd_o = rif.freq_cmd;
  assign jog_active_o = rif.jog_active;
  assign ramp_stop_o = st_reg.ramp_stop;
  assign start_permit_o = st_reg.start_ok;
  assign relay_o = st_reg.relay;
  assign station_addr_o = st_reg.addr;
  assign baud_code_o = st_reg.baud;
  assign cfg_refused_o = st_reg.refused;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_profile_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i != PROFILE_ALT |=> !start_permit_o && !ramp_stop_o && status_word_o == 16'h0000)
    else $error("words interpreted outside the selected profile");
  a_ramp_stop_req: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT && !(&st_reg.cmd[2:0]) |=> ramp_stop_o && !start_permit_o)
    else $error("ramped stop not requested");
  a_relay_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT && relay_sel_i |=> relay_o == ($past(out_freq_i) == 16'h0000))
    else $error("relay does not follow zero frequency");
  a_start_permit: assert property (@(posedge mclk_i) disable iff (srst_i)
    start_permit_o |-> $past(&st_reg.cmd[2:0] && start_cond_i))
    else $error("start permitted without conditions");
  a_ready_bit: assert property (@(posedge mclk_i) disable iff (srst_i)
    status_word_o[0] |-> $past(&st_reg.cmd[2:0] && drive_ready_i))
    else $error("ready bit set while halted or not ready");
  a_coast_bit: assert property (@(posedge mclk_i) disable iff (srst_i)
    status_word_o[2] |-> $past(&st_reg.cmd[3:0] && !trip_i))
    else $error("coasting bit set without all commands");
  a_status_inv: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT |=> status_word_o[5:4] == ~$past(st_reg.cmd[2:1]))
    else $error("halt echo bits not inverted");
  a_inhibit_clear: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT && !st_reg.trip_d && !cmd_we_i
    && st_reg.cmd[10:0] == 11'h406 |=> !st_reg.inhibit)
    else $error("start inhibit not cleared");
  a_spare_bit: assert property (@(posedge mclk_i) disable iff (srst_i)
    !status_word_o[12])
    else $error("unassigned condition bit set");
  a_addr_refuse: assert property (@(posedge mclk_i) disable iff (srst_i)
    ser_cfg_we_i && !loc_addr_we_i && !loc_baud_we_i
    |=> $stable(station_addr_o) && $stable(baud_code_o) && cfg_refused_o)
    else $error("serial configuration change accepted");
  a_addr_range: assert property (@(posedge mclk_i) disable iff (srst_i)
    loc_addr_we_i && protocol_i == PROTO_RTU && loc_addr_i > 8'hF7
    |=> $stable(station_addr_o) && cfg_refused_o)
    else $error("address outside range accepted");
  a_baud_range: assert property (@(posedge mclk_i) disable iff (srst_i)
    baud_code_o <= 3'h5)
    else $error("bit rate code out of range");

  a_ready_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT && drive_ready_i && (&st_reg.cmd[2:0]) |=> status_word_o[0])
    else $error("ready bit not set while ready");

  a_coast_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT && (&st_reg.cmd[3:0]) && !trip_i |=> status_word_o[2])
    else $error("coasting bit not set with all commands");

  a_status_flags: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i == PROFILE_ALT
    |=> status_word_o[3] == $past(trip_i) && status_word_o[7] == $past(warn_i)
    && status_word_o[8] == $past(at_ref_i) && status_word_o[9] == $past(ser_allowed_i)
    && status_word_o[10] == $past(in_limits_i) && status_word_o[11] == $past(running_i)
    && status_word_o[13] == $past(volt_warn_i) && status_word_o[14] == $past(cur_limit_i)
    && status_word_o[15] == $past(therm_warn_i))
    else $error("condition flags do not follow their inputs");

  a_freq_echo: assert property (@(posedge mclk_i) disable iff (srst_i)
    !srst_i |=> out_freq_word_o == $past(out_freq_i))
    else $error("output frequency word not returned");

  a_inhibit_set: assert property (@(posedge mclk_i) disable iff (srst_i)
    cmd_we_i && st_reg.cmd[1] && !cmd_word_i[1] |=> st_reg.inhibit)
    else $error("start inhibit not set on halt request");

  a_jog_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    profile_i != PROFILE_ALT |=> !jog_active_o)
    else $error("jog used outside the selected profile");

  a_relay_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
    !relay_sel_i |=> !relay_o)
    else $error("relay energised without its option");

  a_addr_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !loc_addr_we_i |=> $stable(station_addr_o))
    else $error("address changed without a local write");

  a_baud_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    !loc_baud_we_i |=> $stable(baud_code_o))
    else $error("bit rate changed without a local write");

endmodule

// >>> core/dfwh_pkg.sv
// Constants and types shared by the fieldbus word handler
package dfwh_pkg;

  // ----------------------------------------
  // Command word bit positions
  // ----------------------------------------
  localparam int CW_HALT_A = 0;
  localparam int CW_HALT_B = 1;
  localparam int CW_HALT_C = 2;
  localparam int CW_COAST_N = 3;
  localparam int CW_JOG1 = 8;
  localparam int CW_JOG2 = 9;
  localparam int CW_DATA_OK = 10;
  localparam int CW_SLOW = 11;
  localparam int CW_CATCH = 12;

  // ----------------------------------------
  // Condition word bit positions
  // ----------------------------------------
  localparam int SW_CTRL_RDY = 0;
  localparam int SW_DRV_RDY = 1;
  localparam int SW_COAST_OK = 2;
  localparam int SW_TRIP = 3;
  localparam int SW_HALT_B = 4;
  localparam int SW_HALT_C = 5;
  localparam int SW_INHIBIT = 6;
  localparam int SW_WARN = 7;
  localparam int SW_AT_REF = 8;
  localparam int SW_SER_OK = 9;
  localparam int SW_IN_LIM = 10;
  localparam int SW_RUN = 11;
  localparam int SW_SPARE = 12;
  localparam int SW_VOLT = 13;
  localparam int SW_CUR_LIM = 14;
  localparam int SW_THERM = 15;

  // ----------------------------------------
  // Reset values, codes and limits
  // ----------------------------------------
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [2:0] BAUD_RST = 3'h5;
  localparam logic [2:0] BAUD_MAX = 3'h5;
  localparam logic INHIBIT_RST = 1'b1;
  localparam logic [1:0] PROFILE_ALT = 2'h0;
  localparam logic [1:0] PROTO_NATIVE = 2'h0;
  localparam logic [1:0] PROTO_BAS = 2'h1;
  localparam logic [1:0] PROTO_RTU = 2'h3;
  localparam logic [7:0] ADDR_NATIVE_MAX = 8'hF7;
  localparam logic [7:0] ADDR_BAS_MAX = 8'hFF;
  localparam logic [7:0] ADDR_RTU_MAX = 8'hF7;
  localparam logic [7:0] ADDR_ONE = 8'h01;
  localparam logic signed [16:0] REF_POS_MAX = 17'sh07FFF;
  localparam logic signed [16:0] REF_NEG_MAX = 17'sh18001;

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] setpoint;
    logic [15:0] status;
    logic [15:0] freq;
    logic [7:0] addr;
    logic [2:0] baud;
    logic inhibit;
    logic trip_d;
    logic ramp_stop;
    logic start_ok;
    logic relay;
    logic refused;
  } dfwh_top_st_t;

  typedef struct packed {
    logic [15:0] freq;
    logic jog;
  } dfwh_shp_st_t;

endpackage

// >>> core/dfwh_ref_if.sv
// Signals between the word handler and its reference shaper
interface dfwh_ref_if;
  logic [15:0] setpoint;
  logic [15:0] adj_amt;
  logic [15:0] jog1_freq;
  logic [15:0] jog2_freq;
  logic slow;
  logic catch_up;
  logic jog1;
  logic jog2;
  logic [15:0] freq_cmd;
  logic jog_active;

  modport handler
  (
    output setpoint, adj_amt, jog1_freq, jog2_freq, slow, catch_up, jog1, jog2,
    input freq_cmd, jog_active
  );

  modport shaper
  (
    input setpoint, adj_amt, jog1_freq, jog2_freq, slow, catch_up, jog1, jog2,
    output freq_cmd, jog_active
  );
endinterface

// >>> core/dfwh_ref_shaper.sv
// Speed reference shaping: slow-down, catch-up, bus jog and clamping
module dfwh_ref_shaper
  import dfwh_pkg::*;
(
  input wire logic mclk_i,        // System clock
  input wire logic srst_i,        // Synchronous reset
  dfwh_ref_if.shaper rif          // Reference path to the handler
);

  dfwh_shp_st_t st_reg;
  dfwh_shp_st_t st_next;
  logic signed [16:0] base;
  logic signed [16:0] adj;
  logic signed [16:0] sum;

  // ----------------------------------------
  // Saturate to the symmetric 16-bit range
  // ----------------------------------------
  function automatic logic [15:0] sat16(input logic signed [16:0] v);
    if (v > REF_POS_MAX)
    begin
      return REF_POS_MAX[15:0];
    end
    if (v < REF_NEG_MAX)
    begin
      return REF_NEG_MAX[15:0];
    end
    return v[15:0];
  endfunction

  always_comb
  begin
    st_next = st_reg;
    base = signed'({rif.setpoint[15], rif.setpoint});
    adj = signed'({rif.adj_amt[15], rif.adj_amt});
    if (rif.slow)
    begin
      sum = base - adj;
    end
    else if (rif.catch_up)
    begin
      sum = base + adj;
    end
    else
    begin
      sum = base;
    end
    if (rif.jog1)
    begin
      st_next.freq = rif.jog1_freq;
    end
    else if (rif.jog2)
    begin
      st_next.freq = rif.jog2_freq;
    end
    else
    begin
      st_next.freq = sat16(sum);
    end
    st_next.jog = rif.jog1 | rif.jog2;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      st_reg <= '{freq: WORD_RST, jog: 1'b0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rif.freq_cmd = st_reg.freq;
  assign rif.jog_active = st_reg.jog;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_slow_priority: assert property (@(posedge mclk_i) disable iff (srst_i)
    rif.slow && rif.catch_up && !rif.jog1 && !rif.jog2
    && $signed(rif.setpoint) > 16'sh0100 && rif.adj_amt == 16'h0001
    |=> $signed(rif.freq_cmd) == $signed($past(rif.setpoint)) - 16'sh0001)
    else $error("slow-down did not win over catch-up");
  a_jog_select: assert property (@(posedge mclk_i) disable iff (srst_i)
    rif.jog1 |=> rif.freq_cmd == $past(rif.jog1_freq) && rif.jog_active)
    else $error("first jog frequency not selected");
  a_ref_clamp: assert property (@(posedge mclk_i) disable iff (srst_i)
    !rif.jog_active |-> rif.freq_cmd != 16'h8000)
    else $error("reference left the symmetric range");

endmodule

// >>> sim/dfwh_master_model.sv
// Behavioural fieldbus master writing command words, setpoints and config attempts
module dfwh_master_model
(
  input wire logic mclk_i,         // System clock
  output logic cmd_we_o,           // Command word strobe
  output logic [15:0] cmd_word_o,  // Command word
  output logic ref_we_o,           // Setpoint strobe
  output logic [15:0] ref_word_o,  // Setpoint word
  output logic ser_cfg_we_o        // Serial attempt to change address or rate
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_we_o = 1'b0;
    cmd_word_o = 16'h0000;
    ref_we_o = 1'b0;
    ref_word_o = 16'h0000;
    ser_cfg_we_o = 1'b0;
  end

  // ----------------------------------------
  // Transfers, each started at a falling edge
  // ----------------------------------------
  task automatic send_cmd(input logic [15:0] w);
    cmd_we_o = 1'b1;
    cmd_word_o = w;
    @(negedge mclk_i);
    cmd_we_o = 1'b0;
    cmd_word_o = ~w;  // Released bus does not keep the last word
  endtask

  task automatic send_ref(input logic [15:0] mag, input logic neg);
    ref_we_o = 1'b1;
    ref_word_o = neg ? (~mag + 16'h0001) : mag;
    @(negedge mclk_i);
    ref_we_o = 1'b0;
    ref_word_o = ~ref_word_o;
  endtask

  task automatic try_cfg();
    ser_cfg_we_o = 1'b1;
    @(negedge mclk_i);
    ser_cfg_we_o = 1'b0;
  endtask
endmodule

// >>> sim/drive_fieldbus_word_handler_tb.sv
// Self-checking bench for the fieldbus word handler
module drive_fieldbus_word_handler_tb;
  import dfwh_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int k; logic [15:0] m; logic [15:0] e;} dfwh_note_t;
  dfwh_note_t q[$];
  int errors = 0;
  int compares = 0;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] profile = 2'h0;
  logic [15:0] adj = 16'h0000;
  logic [15:0] jog1 = 16'h1234;
  logic [15:0] jog2 = 16'h0567;
  logic [15:0] ofreq = 16'h0000;
  logic [11:0] st_in = 12'h000;
  logic [1:0] proto = 2'h0;
  logic loc_addr_we = 1'b0;
  logic [7:0] loc_addr = 8'h00;
  logic loc_baud_we = 1'b0;
  logic [2:0] loc_baud = 3'h0;
  logic cmd_we, ref_we, ser_we, jog_active, ramp_stop, start_permit, relay, cfg_refused;
  logic [15:0] cmd_word, ref_word, status_word, out_freq_word, speed_cmd;
  logic [7:0] station_addr;
  logic [2:0] baud_code;
  logic [7:0] ea = 8'h01;
  logic [2:0] eb = 3'h5;
  logic [15:0] c;
  logic [1:0] cp [9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3, 2'h2};
  logic [7:0] ca [9] = '{8'h00, 8'hF7, 8'hF8, 8'h00, 8'hFF, 8'h00, 8'hF7, 8'hF8, 8'h05};
  logic co [9] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic [15:0] tm [10] = '{16'h2000, 16'h2000, 16'h2000, 16'h2000, 16'h7F00, 16'h2000,
                           16'h2000, 16'h2000, 16'h2000, 16'h2000};
  logic tn [10] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  logic [15:0] ta [10] = '{16'h0100, 16'h0100, 16'h0100, 16'h0001, 16'h0200, 16'h7000,
                           16'h0100, 16'h0100, 16'h0100, 16'h0100};
  logic [15:0] tb [10] = '{16'h0000, 16'h0800, 16'h1000, 16'h1800, 16'h1000, 16'h0800,
                           16'h0000, 16'h0100, 16'h0200, 16'h0300};
  logic [15:0] te [10] = '{16'h2000, 16'h1F00, 16'h2100, 16'h1FFF, 16'h7FFF, 16'h8001,
                           16'hE000, 16'h1234, 16'h0567, 16'h1234};

  always #2 mclk = ~mclk;

  dfwh_master_model m (.mclk_i(mclk), .cmd_we_o(cmd_we), .cmd_word_o(cmd_word),
    .ref_we_o(ref_we), .ref_word_o(ref_word), .ser_cfg_we_o(ser_we));

  dfwh_word_handler dut (.mclk_i(mclk), .srst_i(srst), .profile_i(profile),
    .cmd_we_i(cmd_we), .cmd_word_i(cmd_word), .ref_we_i(ref_we), .ref_word_i(ref_word),
    .adj_amt_i(adj), .jog1_freq_i(jog1), .jog2_freq_i(jog2), .out_freq_i(ofreq),
    .start_cond_i(st_in[0]), .relay_sel_i(st_in[1]), .drive_ready_i(st_in[2]),
    .trip_i(st_in[3]), .warn_i(st_in[4]), .at_ref_i(st_in[5]), .ser_allowed_i(st_in[6]),
    .in_limits_i(st_in[7]), .running_i(st_in[8]), .volt_warn_i(st_in[9]),
    .cur_limit_i(st_in[10]), .therm_warn_i(st_in[11]), .protocol_i(proto),
    .loc_addr_we_i(loc_addr_we), .loc_addr_i(loc_addr), .loc_baud_we_i(loc_baud_we),
    .loc_baud_i(loc_baud), .ser_cfg_we_i(ser_we), .status_word_o(status_word),
    .out_freq_word_o(out_freq_word), .speed_cmd_o(speed_cmd), .jog_active_o(jog_active),
    .ramp_stop_o(ramp_stop), .start_permit_o(start_permit), .relay_o(relay),
    .station_addr_o(station_addr), .baud_code_o(baud_code), .cfg_refused_o(cfg_refused));

  // ----------------------------------------
  // Expectations and their checker
  // ----------------------------------------
  function automatic logic [15:0] obs(input int k);
    case (k)
      0: obs = status_word;
      1: obs = speed_cmd;
      2: obs = out_freq_word;
      3: obs = {11'h000, jog_active, ramp_stop, start_permit, relay, cfg_refused};
      4: obs = {8'h00, station_addr};
      default: obs = {13'h0000, baud_code};
    endcase
  endfunction

  // Condition word from the command and the level inputs, start inhibit left as zero
  function automatic logic [15:0] exp_st(input logic [15:0] w);
    exp_st = {st_in[11:9], 1'b0, st_in[8:4], 1'b0, ~w[2], ~w[1], st_in[3],
              (&w[3:0]) & ~st_in[3], st_in[2], (&w[2:0]) & st_in[2]};
  endfunction

  task automatic expect_val(input int k, input logic [15:0] msk, input logic [15:0] e);
    q.push_back('{k, msk, e & msk});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [15:0] w);
    m.send_cmd(w);
    settle(2);
  endtask

  task automatic loc(input logic sel, input logic [7:0] v);
    loc_addr_we = ~sel;
    loc_baud_we = sel;
    loc_addr = v;
    loc_baud = v[2:0];
    settle(1);
    loc_addr_we = 1'b0;
    loc_baud_we = 1'b0;
    loc_addr = ~v;
    loc_baud = ~v[2:0];
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    dfwh_note_t n;
    forever
    begin
      @(negedge mclk);
      #1;
      while (q.size() > 0)
      begin
        n = q.pop_front();
        compares++;
        if ((obs(n.k) & n.m) !== n.e)
        begin
          errors++;
          $display("mismatch at %0t: got %h expected %h", $time, obs(n.k) & n.m, n.e);
        end
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    void'($urandom(33));
    settle(16);
    srst = 1'b0;
    settle(2);
    expect_val(4, 16'h00FF, 16'h0001);
    expect_val(5, 16'h0007, 16'h0005);
    expect_val(0, 16'h0040, 16'h0040);
    st_in = 12'h005;
    wr(16'h0406);
    expect_val(0, 16'h0040, 16'h0000);
    expect_val(3, 16'h000C, 16'h0008);
    wr(16'h047F);
    expect_val(3, 16'h000E, 16'h0004);
    expect_val(0, 16'hFFFF, exp_st(16'h047F));
    wr(16'h047D);
    expect_val(0, 16'h0040, 16'h0040);
    expect_val(3, 16'h000C, 16'h0008);
    for (int i = 0; i < 8; i++)
    begin
      st_in = 12'($urandom);
      ofreq = (i % 2 == 0) ? 16'h0000 : 16'($urandom);
      c = 16'($urandom) | ((i < 2) ? 16'h000F : 16'h0000);
      wr(c);
      expect_val(0, 16'hFFBF, exp_st(c));
      expect_val(2, 16'hFFFF, ofreq);
      expect_val(3, 16'h000A, {12'h000, ~&c[2:0], 1'b0, st_in[1] && ofreq == 16'h0000, 1'b0});
    end
    st_in = 12'h005;
    ofreq = 16'h0100;
    for (int i = 0; i < 10; i++)
    begin
      adj = ta[i];
      m.send_ref(tm[i], tn[i]);
      wr(16'h047F | tb[i]);
      settle(1);
      expect_val(1, 16'hFFFF, te[i]);
      expect_val(3, 16'h0010, {11'h000, |tb[i][9:8], 4'h0});
    end
    profile = 2'h1;
    st_in = 12'h007;
    ofreq = 16'h0000;
    wr(16'h0C7F);
    settle(1);
    expect_val(0, 16'hFFFF, 16'h0000);
    expect_val(3, 16'h001E, 16'h0000);
    expect_val(1, 16'hFFFF, 16'h2000);
    profile = 2'h0;
    for (int i = 0; i < 9; i++)
    begin
      proto = cp[i];
      loc(1'b0, ca[i]);
      if (co[i])
        ea = ca[i];
      expect_val(3, 16'h0001, {15'h0000, ~co[i]});
      expect_val(4, 16'h00FF, {8'h00, ea});
      settle(1);
    end
    m.try_cfg();
    expect_val(3, 16'h0001, 16'h0001);
    expect_val(4, 16'h00FF, {8'h00, ea});
    settle(1);
    for (int i = 0; i < 8; i++)
    begin
      loc(1'b1, 8'(i));
      if (i < 6)
        eb = 3'(i);
      expect_val(3, 16'h0001, {15'h0000, i > 5});
      expect_val(5, 16'h0007, {13'h0000, eb});
      settle(1);
    end
    srst = 1'b1;
    settle(2);
    srst = 1'b0;
    settle(2);
    expect_val(4, 16'h00FF, 16'h0001);
    expect_val(5, 16'h0007, 16'h0005);
    expect_val(0, 16'h0040, 16'h0040);
    settle(2);
    report_and_stop();
  end
endmodule
